// ==== hdl/scg_clock_unit.sv ====
// System clock generation unit: source select, prescalers, calibration, failure monitor
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "scg_regs.svh"
module scg_clock_unit #(
  parameter int CAL_W = 7,
  parameter int DCNT_W = 16,
  parameter logic [15:0] COMP_2M = 16'h07a1,
  parameter logic [15:0] COMP_32M = 16'h7a12
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // APB slave
  input wire scg_pkg::scg_apb_req_t i_apb,
  output scg_pkg::scg_apb_rsp_t o_apb,
  // Oscillator ticks and ready flags: rc2m, rc32m, rc32k, xosc, pll, low-freq crystal
  input wire logic [5:0] i_src_tick,
  input wire logic [5:0] i_src_ready,
  input wire logic i_ulp_tick,
  // Power and failure
  input wire logic i_cpu_halt,
  input wire logic i_sleep_deep,
  input wire logic i_xosc_fail,
  // Factory calibration values
  input wire logic [CAL_W-1:0] i_fuse_cal32k,
  input wire logic [CAL_W-1:0] i_fuse_cal2m,
  input wire logic [CAL_W-1:0] i_fuse_cal32m,
  // Derived clock enables
  output scg_pkg::scg_clk_en_t o_clk_en,
  output logic o_rtc_async_clock,
  output logic o_ulp_1k_tick,
  output logic o_rc32k_1k_tick,
  // Oscillator controls and failure NMI
  output logic [5:0] o_osc_en,
  output logic o_ultra_low_power_osc_en,
  output logic [1:0] o_xosc_mode,
  output logic o_crystal_output_pin_release,
  output logic o_lf_lowpower,
  output logic [1:0] o_pll_src,
  output logic [4:0] o_pll_fac,
  output logic [CAL_W-1:0] o_cal32k,
  output logic [CAL_W-1:0] o_cal2m,
  output logic [CAL_W-1:0] o_cal32m,
  output logic o_nmi
);
  import scg_pkg::*;

  // Parameter check
  initial begin
    if (CAL_W < 1 || CAL_W > 16 || DCNT_W < 8 || DCNT_W > 16) begin
      $error("scg_clock_unit: unsupported width parameter");
    end
  end

  // Last count of a divide-by-2^n stage
  function automatic logic [8:0] div_last(input logic [3:0] n);
    div_last = 9'((10'h001 << n) - 10'h001);
  endfunction

  // Saturating step of a calibration value
  function automatic logic [CAL_W-1:0] cal_step(input logic [CAL_W-1:0] v, input logic up);
    logic [CAL_W-1:0] mx;
    mx = '1;
    if (up) begin
      cal_step = (v == mx) ? v : CAL_W'(v + 1'b1);
    end else begin
      cal_step = (v == '0) ? v : CAL_W'(v - 1'b1);
    end
  endfunction

  logic rst_q1;
  logic rst_n;
  // Reset release through two flops
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  logic [2:0] sel;
  logic [2:0] pend_sel;
  logic [3:0] psa;
  logic [1:0] psbc;
  logic [3:0] psa_act;
  logic [1:0] psbc_act;
  logic [5:0] osc_en;
  logic [3:0] xosc_cfg;
  logic [2:0] rtc_cfg;
  logic [4:0] pll_fac;
  logic [1:0] pll_src;
  logic [3:0] frequency_lock_calibrator_cfg;
  logic [CAL_W-1:0] cal32k;
  logic [CAL_W-1:0] cal_rc [2];
  logic fail_en;
  logic fail_flag;
  logic load_pend;
  logic [8:0] cnt_a;
  logic [1:0] cnt_b;
  logic cnt_c;
  logic [4:0] cnt32 [3];
  logic [DCNT_W-1:0] dcnt [2];
  logic [31:0] prdata;
  logic slverr;

  // APB decode
  logic wr;
  logic setup;
  logic [7:0] addr;
  logic [31:0] wd;
  logic mapped;
  assign wr = i_apb.psel && i_apb.penable && i_apb.pwrite;
  assign setup = i_apb.psel && !i_apb.penable;
  assign addr = i_apb.paddr;
  assign wd = i_apb.pwdata;
  assign mapped = (addr[1:0] == 2'h0) && (addr <= `SCG_OFF_FAIL);

  // Main selected clock and failure conditions
  logic main_selected_clock;
  logic fail_sys;
  logic fail_evt;
  logic mon_on;
  assign main_selected_clock = i_src_tick[sel];
  assign mon_on = fail_en && !i_sleep_deep;
  assign fail_evt = mon_on && i_xosc_fail;
  assign fail_sys = (sel == `SCG_SRC_XOSC) || (sel == `SCG_SRC_PLL && pll_src >= `SCG_PLLREF_XOSC);

  // Prescaler chain pulses
  logic [1:0] b_last;
  logic c_last;
  logic pls4;
  logic pls2;
  logic pls1;
  // Stage B and C last counts
  always_comb begin
    unique case (psbc_act)
      2'h0: begin b_last = 2'h0; c_last = 1'b0; end
      2'h1: begin b_last = 2'h0; c_last = 1'b1; end
      2'h2: begin b_last = 2'h1; c_last = 1'b1; end
      2'h3: begin b_last = 2'h3; c_last = 1'b0; end
    endcase
  end
  assign pls4 = main_selected_clock && (cnt_a == div_last(psa_act));
  assign pls2 = pls4 && (cnt_b == b_last);
  assign pls1 = pls2 && (cnt_c == c_last);

  assign o_clk_en.quad_rate_peripheral_clock = pls4 && !i_sleep_deep;
  assign o_clk_en.double_rate_peripheral_clock = pls2 && !i_sleep_deep;
  assign o_clk_en.peripheral_clock = pls1 && !i_sleep_deep;
  assign o_clk_en.processor_clock = pls1 && !i_sleep_deep && !i_cpu_halt;

  // Prescaler counters, 512 x 4 at most
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_a <= '0;
      cnt_b <= '0;
      cnt_c <= 1'b0;
    end else if (main_selected_clock) begin
      cnt_a <= pls4 ? 9'h000 : 9'(cnt_a + 1'b1);
      if (pls4) begin
        cnt_b <= pls2 ? 2'h0 : 2'(cnt_b + 1'b1);
      end
      if (pls2) begin
        cnt_c <= pls1 ? 1'b0 : !cnt_c;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      psa_act <= '0;
      psbc_act <= '0;
    end else if (pls1) begin
      psa_act <= psa;
      psbc_act <= psbc;
    end
  end

  // Prescaler setting, stage A up to 2^9
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      psa <= '0;
      psbc <= '0;
    end else if (wr && addr == `SCG_OFF_PSC && wd[3:0] <= `SCG_PSA_MAX) begin
      psa <= wd[3:0];
      psbc <= wd[5:4];
    end
  end

  // Source selection request and switch
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel <= `SCG_SRC_RC2M;
      pend_sel <= `SCG_SRC_RC2M;
    end else if (fail_evt && fail_sys) begin
      sel <= `SCG_SRC_RC2M;
      pend_sel <= `SCG_SRC_RC2M;
    end else begin
      if (wr && addr == `SCG_OFF_CTRL && wd[2:0] <= `SCG_SRC_LFX
          && osc_en[wd[2:0]] && i_src_ready[wd[2:0]]) begin
        pend_sel <= wd[2:0];
      end
      // Change at end of old period
      if (pend_sel != sel && i_src_tick[sel]) begin
        sel <= pend_sel;
      end
    end
  end

  // Oscillator enables
  logic [5:0] en_keep;
  always_comb begin
    en_keep = '0;
    en_keep[sel] = 1'b1;
    en_keep[pend_sel] = 1'b1;
  end
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_en <= `SCG_OSCEN_RST;
    end else if (fail_evt && fail_sys) begin
      osc_en <= `SCG_OSCEN_RST;
    end else if (fail_evt) begin
      osc_en[`SCG_IDX_XOSC] <= 1'b0;
    end else if (wr && addr == `SCG_OFF_OSCEN) begin
      osc_en <= wd[5:0] | en_keep;
    end
  end

  // Crystal mode, external input, low power
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      xosc_cfg <= '0;
    end else if (wr && addr == `SCG_OFF_XOSC && !osc_en[`SCG_IDX_XOSC]) begin
      xosc_cfg <= wd[3:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_fac <= 5'h01;
      pll_src <= '0;
    end else if (wr && addr == `SCG_OFF_PLL && !osc_en[`SCG_IDX_PLL] && wd[4:0] != 5'h00) begin
      pll_fac <= wd[4:0];
      pll_src <= wd[`SCG_PLL_SRC_LSB +: 2];
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rtc_cfg <= '0;
    end else if (wr && addr == `SCG_OFF_RTC && wd[1:0] <= `SCG_RTC_ULP) begin
      rtc_cfg <= wd[2:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      frequency_lock_calibrator_cfg <= '0;
    end else if (wr && addr == `SCG_OFF_FREQUENCY_LOCK_CALIBRATOR) begin
      frequency_lock_calibrator_cfg <= wd[3:0];
    end
  end

  // Divide-by-32 prescalers: 0 ulp, 1 rc32k, 2 low-freq crystal
  logic [2:0] t32;
  logic [2:0] t1k;
  assign t32 = {i_src_tick[`SCG_SRC_LFX], i_src_tick[`SCG_SRC_RC32K], i_ulp_tick};
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        cnt32[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (t32[i]) begin
          cnt32[i] <= 5'(cnt32[i] + 1'b1);
        end
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      t1k[i] = t32[i] && (cnt32[i] == `SCG_DIV32_LAST);
    end
  end
  assign o_ulp_1k_tick = t1k[0];
  assign o_rc32k_1k_tick = t1k[1];

  // RTC clock, not gated by sleep
  always_comb begin
    unique case (rtc_cfg[1:0])
      `SCG_RTC_LFX: o_rtc_async_clock = rtc_cfg[`SCG_RTC_EN_BIT] && t32[2];
      `SCG_RTC_RC32K: o_rtc_async_clock = rtc_cfg[`SCG_RTC_EN_BIT] && t32[1];
      default: o_rtc_async_clock = rtc_cfg[`SCG_RTC_EN_BIT] && t32[0];
    endcase
  end
  assign o_ultra_low_power_osc_en = rtc_cfg[`SCG_RTC_EN_BIT] && rtc_cfg[1:0] == `SCG_RTC_ULP;

  // Reset-time factory load pending flag
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_pend <= 1'b1;
    end else begin
      load_pend <= 1'b0;
    end
  end

  // 32.768 kHz calibration load and write
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal32k <= '0;
    end else if (load_pend) begin
      cal32k <= i_fuse_cal32k;
    end else if (wr && addr == `SCG_OFF_CAL32K) begin
      cal32k <= wd[CAL_W-1:0];
    end
  end

  // Frequency lock calibrators, one per fast RC
  logic [1:0] dref;
  logic [DCNT_W-1:0] dcomp [2];
  assign dcomp[0] = DCNT_W'(COMP_2M);
  assign dcomp[1] = DCNT_W'(COMP_32M);
  assign dref[0] = frequency_lock_calibrator_cfg[2] ? t1k[2] : t1k[1];
  assign dref[1] = frequency_lock_calibrator_cfg[3] ? t1k[2] : t1k[1];
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < 2; k++) begin
        dcnt[k] <= '0;
        cal_rc[k] <= '0;
      end
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (load_pend) begin
          cal_rc[k] <= (k == 0) ? i_fuse_cal2m : i_fuse_cal32m;
        end else if (frequency_lock_calibrator_cfg[k] && dref[k]) begin
          if (dcnt[k] != dcomp[k]) begin
            cal_rc[k] <= cal_step(cal_rc[k], dcnt[k] < dcomp[k]);
          end
        end else if (!frequency_lock_calibrator_cfg[k] && wr && addr == ((k == 0) ? `SCG_OFF_CAL2M : `SCG_OFF_CAL32M)) begin
          // Manual calibration when loop is off
          cal_rc[k] <= wd[CAL_W-1:0];
        end
        if (!frequency_lock_calibrator_cfg[k] || dref[k]) begin
          dcnt[k] <= '0;
        end else if (i_src_tick[k]) begin
          dcnt[k] <= DCNT_W'(dcnt[k] + 1'b1);
        end
      end
    end
  end

  // Failure monitor: enable sticks until reset, flag cleared by writing one
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fail_en <= 1'b0;
      fail_flag <= 1'b0;
      o_nmi <= 1'b0;
    end else begin
      if (wr && addr == `SCG_OFF_FAIL && wd[`SCG_FAIL_EN_BIT]) begin
        fail_en <= 1'b1;
      end
      // Flag and NMI on system failure
      if (fail_evt && fail_sys) begin
        fail_flag <= 1'b1;
      end else if (wr && addr == `SCG_OFF_FAIL && wd[`SCG_FAIL_FLAG_BIT]) begin
        fail_flag <= 1'b0;
      end
      o_nmi <= fail_evt && fail_sys;
    end
  end

  // APB read data captured in setup phase
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
      slverr <= 1'b0;
    end else if (setup) begin
      slverr <= !mapped;
      prdata <= '0;
      unique case (addr)
        `SCG_OFF_CTRL: prdata[2:0] <= sel;
        `SCG_OFF_PSC: prdata[5:0] <= {psbc, psa};
        `SCG_OFF_OSCEN: prdata[5:0] <= osc_en;
        `SCG_OFF_OSCSTAT: prdata[6:0] <= {o_ultra_low_power_osc_en, osc_en & i_src_ready};
        `SCG_OFF_XOSC: prdata[3:0] <= xosc_cfg;
        `SCG_OFF_RTC: prdata[2:0] <= rtc_cfg;
        `SCG_OFF_PLL: prdata[7:0] <= {pll_src, 1'b0, pll_fac};
        `SCG_OFF_FREQUENCY_LOCK_CALIBRATOR: prdata[3:0] <= frequency_lock_calibrator_cfg;
        `SCG_OFF_CAL32K: prdata[CAL_W-1:0] <= cal32k;
        `SCG_OFF_CAL2M: prdata[CAL_W-1:0] <= cal_rc[0];
        `SCG_OFF_CAL32M: prdata[CAL_W-1:0] <= cal_rc[1];
        `SCG_OFF_FAIL: prdata[1:0] <= {fail_flag, fail_en};
        default: prdata <= '0;
      endcase
    end
  end
  assign o_apb.pready = 1'b1;
  assign o_apb.prdata = prdata;
  assign o_apb.pslverr = slverr && i_apb.psel && i_apb.penable;

  // Control outputs
  assign o_osc_en = osc_en;
  assign o_xosc_mode = xosc_cfg[1:0];
  assign o_crystal_output_pin_release = xosc_cfg[`SCG_XOSC_EXT_BIT];
  assign o_lf_lowpower = xosc_cfg[`SCG_XOSC_LP_BIT];
  assign o_pll_src = pll_src;
  assign o_pll_fac = pll_fac;
  assign o_cal32k = cal32k;
  assign o_cal2m = cal_rc[0];
  assign o_cal32m = cal_rc[1];

  // Checks
  a_reset_src_2m: assert property (@(posedge i_sys_clk) $rose(rst_n) |-> sel == `SCG_SRC_RC2M
    && !osc_en[`SCG_IDX_PLL]) else $error("source not 2 MHz RC after reset");
  a_frequency_lock_calibrator_off_rst: assert property (@(posedge i_sys_clk) $rose(rst_n) |-> frequency_lock_calibrator_cfg[1:0] == 2'h0)
    else $error("calibrator on after reset");
  a_cpu_halt_gate: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    i_cpu_halt |-> !o_clk_en.processor_clock) else $error("cpu clock during halt");
  a_fast_nesting: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    o_clk_en.peripheral_clock |-> o_clk_en.double_rate_peripheral_clock
    && o_clk_en.quad_rate_peripheral_clock) else $error("derived clocks out of phase");
  a_sel_refused: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (wr && addr == `SCG_OFF_CTRL && !fail_evt && !(i_src_ready[wd[2:0]] && osc_en[wd[2:0]]))
    |=> pend_sel == $past(pend_sel))
    else $error("unready source accepted");
  a_fail_switch: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (fail_evt && fail_sys) |=> sel == `SCG_SRC_RC2M && o_nmi && fail_flag)
    else $error("failure not handled");
  a_cal_load: assert property (@(posedge i_sys_clk) $rose(rst_n) |=> cal32k == $past(i_fuse_cal32k)
    && o_cal2m == $past(i_fuse_cal2m)) else $error("factory calibration not loaded");
  a_ulp_auto: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    o_ulp_1k_tick |=> cnt32[0] == 5'h00) else $error("ulp divider");
  a_psc_hold: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    $changed(psa_act) |-> $past(pls1)) else $error("prescaler changed mid period");
  a_src_switch: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    ($changed(sel) && sel != `SCG_SRC_RC2M) |-> $past(main_selected_clock))
    else $error("source switched mid period");
endmodule // scg_clock_unit

// ==== hdl/scg_regs.svh ====
// Register offsets, field positions, reset values and codes of the clock unit
`ifndef SCG_REGS_SVH
`define SCG_REGS_SVH
`define SCG_OFF_CTRL 8'h00
`define SCG_OFF_PSC 8'h04
`define SCG_OFF_OSCEN 8'h08
`define SCG_OFF_OSCSTAT 8'h0c
`define SCG_OFF_XOSC 8'h10
`define SCG_OFF_RTC 8'h14
`define SCG_OFF_PLL 8'h18
`define SCG_OFF_FREQUENCY_LOCK_CALIBRATOR 8'h1c
`define SCG_OFF_CAL32K 8'h20
`define SCG_OFF_CAL2M 8'h24
`define SCG_OFF_CAL32M 8'h28
`define SCG_OFF_FAIL 8'h2c
`define SCG_NSRC 6
`define SCG_SRC_RC2M 3'h0
`define SCG_SRC_RC32M 3'h1
`define SCG_SRC_RC32K 3'h2
`define SCG_SRC_XOSC 3'h3
`define SCG_SRC_PLL 3'h4
`define SCG_SRC_LFX 3'h5
`define SCG_IDX_RC2M 0
`define SCG_IDX_RC32M 1
`define SCG_IDX_XOSC 3
`define SCG_IDX_PLL 4
`define SCG_OSCEN_RST 6'h01
`define SCG_PSA_MAX 4'h9
`define SCG_RTC_LFX 2'h0
`define SCG_RTC_RC32K 2'h1
`define SCG_RTC_ULP 2'h2
`define SCG_PLLREF_XOSC 2'h2
`define SCG_DIV32_LAST 5'h1f
`define SCG_FAIL_EN_BIT 0
`define SCG_FAIL_FLAG_BIT 1
`define SCG_RTC_EN_BIT 2
`define SCG_XOSC_EXT_BIT 2
`define SCG_XOSC_LP_BIT 3
`define SCG_PLL_SRC_LSB 6
`endif

// ==== hdl/scg_pkg.sv ====
// Types shared by the clock unit and its users
package scg_pkg;
  // APB request from the bus master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } scg_apb_req_t;
  // APB answer to the bus master
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } scg_apb_rsp_t;
  // Derived clock enables, one pulse per clock period
  typedef struct packed {
    logic quad_rate_peripheral_clock;
    logic double_rate_peripheral_clock;
    logic peripheral_clock;
    logic processor_clock;
  } scg_clk_en_t;
endpackage

// ==== verif/scg_osc_model.sv ====
// Behavioural oscillators and crystal that feed the clock unit
`timescale 1ns/1ns
module scg_osc_model (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Bench request to kill the crystal
  input wire logic i_kill_xosc,
  // Oscillator outputs
  output logic [5:0] o_src_tick,
  output logic [5:0] o_src_ready,
  output logic o_ulp_tick,
  output logic o_xosc_fail
);
  logic [3:0] ph;
  logic stable;
  logic [5:0] alive;
  // Free running oscillator phase and start-up delay
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph <= 4'h0;
      stable <= 1'b0;
    end else begin
      ph <= ph + 4'h1;
      stable <= stable | (ph == 4'hf);
    end
  end
  // A dead crystal neither ticks nor reports stable
  assign alive = {2'h3, ~i_kill_xosc, 3'h7};
  assign o_src_tick = ph[0] ? alive : 6'h00;
  assign o_src_ready = stable ? alive : 6'h00;
  assign o_ulp_tick = ph[1:0] == 2'h3;
  assign o_xosc_fail = i_kill_xosc;
endmodule // scg_osc_model

// ==== verif/system_clock_generation_unit_bench.sv ====
// Register level bench for the clock unit
`timescale 1ns/1ns
`include "scg_regs.svh"
module system_clock_generation_unit_bench;
  import scg_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  scg_apb_req_t req = '0;
  scg_apb_rsp_t rsp;
  scg_clk_en_t en;
  logic halt = 1'b0;
  logic deep = 1'b0;
  logic kill = 1'b0;
  logic [5:0] tick, rdy, osc_en;
  logic ultra_low_power_osc, fail, rtc, ulp_en, rel, lp, nmi, u1k, r1k, err;
  logic [1:0] mode, psrc;
  logic [4:0] fac;
  logic [6:0] c32k, c2m, c32m;
  logic [31:0] q;
  int error_cnt = 0;
  int check_count = 0;
  int np, nper, nrtc, nu, nr, nn, cyc, quads;
  always #10 clk = ~clk;
  scg_osc_model osc (.i_sys_clk(clk), .i_rst_n(rst_n), .i_kill_xosc(kill),
    .o_src_tick(tick), .o_src_ready(rdy), .o_ulp_tick(ultra_low_power_osc), .o_xosc_fail(fail));
  scg_clock_unit dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_apb(req), .o_apb(rsp),
    .i_src_tick(tick), .i_src_ready(rdy), .i_ulp_tick(ultra_low_power_osc), .i_cpu_halt(halt),
    .i_sleep_deep(deep), .i_xosc_fail(fail), .i_fuse_cal32k(7'h2a),
    .i_fuse_cal2m(7'h15), .i_fuse_cal32m(7'h33), .o_clk_en(en),
    .o_rtc_async_clock(rtc), .o_ulp_1k_tick(u1k), .o_rc32k_1k_tick(r1k),
    .o_osc_en(osc_en), .o_ultra_low_power_osc_en(ulp_en), .o_xosc_mode(mode),
    .o_crystal_output_pin_release(rel), .o_lf_lowpower(lp), .o_pll_src(psrc),
    .o_pll_fac(fac), .o_cal32k(c32k), .o_cal2m(c2m), .o_cal32m(c32m), .o_nmi(nmi));
  // Closing report
  task automatic give_verdict();
    $display("Checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (rsp.pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      chk(0, 1);
      give_verdict();
    end
    q = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk({err, q}, {1'b0, e});
  endtask
  task automatic rd_wait(input logic [7:0] a, input logic [31:0] e);
    int i;
    i = 0;
    do begin
      apb(1'b0, a, 32'h0);
      i++;
    end while (q !== e && i < 20);
    chk(q, e);
    if (q !== e) begin
      give_verdict();
    end
  endtask
  // Counts derived pulses over n cycles
  task automatic watch(input int n);
    np = 0; nper = 0; nrtc = 0; nu = 0; nr = 0; nn = 0;
    repeat (n) begin
      @(negedge clk);
      np += en.processor_clock; nper += en.peripheral_clock; nrtc += rtc;
      nu += u1k; nr += r1k; nn += nmi;
    end
  endtask
  // Cycles and quad pulses between two processor pulses
  task automatic span();
    int i;
    i = 0; cyc = 0; quads = 0;
    while (en.processor_clock !== 1'b1 && i < 9000) begin
      @(negedge clk);
      i++;
    end
    do begin
      @(negedge clk);
      cyc++;
      quads += en.quad_rate_peripheral_clock;
    end while (en.processor_clock !== 1'b1 && cyc < 9000);
    if (i >= 9000 || cyc >= 9000) begin
      chk(0, 1);
      give_verdict();
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`SCG_OFF_CTRL, 32'h0);
    rd(`SCG_OFF_OSCEN, 32'h1);
    rd(`SCG_OFF_FREQUENCY_LOCK_CALIBRATOR, 32'h0);
    rd(`SCG_OFF_PLL, 32'h1);
    rd(`SCG_OFF_CAL32K, 32'h2a);
    rd(`SCG_OFF_CAL2M, 32'h15);
    rd(`SCG_OFF_CAL32M, 32'h33);
    apb(1'b0, 8'h30, 32'h0);
    chk(err, 1);
    apb(1'b1, `SCG_OFF_CAL32K, 32'h11);
    rd(`SCG_OFF_CAL32K, 32'h11);
    chk(c32k, 7'h11);
    apb(1'b1, `SCG_OFF_CAL2M, 32'h44);
    rd(`SCG_OFF_CAL2M, 32'h44);
    chk(c2m, 7'h44);
    // Ratio of quad to processor rate, then the slowest setting
    apb(1'b1, `SCG_OFF_PSC, 32'h20);
    span(); span();
    chk(cyc, 8);
    chk(quads, 4);
    apb(1'b1, `SCG_OFF_PSC, 32'h39);
    span(); span();
    chk(cyc, 4096);
    chk(quads, 4);
    apb(1'b1, `SCG_OFF_PSC, 32'h0a);
    rd(`SCG_OFF_PSC, 32'h39);
    apb(1'b1, `SCG_OFF_PSC, 32'h00);
    span(); span();
    chk(cyc, 2);
    chk(quads, 1);
    @(posedge clk);
    halt <= 1'b1;
    watch(40);
    chk(np, 0);
    chk(nper, 20);
    @(posedge clk);
    halt <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, `SCG_OFF_XOSC, m);
      chk(mode, m);
    end
    apb(1'b1, `SCG_OFF_XOSC, 32'h0c);
    chk({rel, lp}, 2'h3);
    apb(1'b1, `SCG_OFF_XOSC, 32'h00);
    apb(1'b1, `SCG_OFF_CTRL, 32'h3);
    rd(`SCG_OFF_CTRL, 32'h0);
    apb(1'b1, `SCG_OFF_OSCEN, 32'h0b);
    apb(1'b1, `SCG_OFF_CTRL, 32'h1);
    rd_wait(`SCG_OFF_CTRL, 32'h1);
    apb(1'b1, `SCG_OFF_OSCEN, 32'h08);
    rd(`SCG_OFF_OSCEN, 32'h0a);
    apb(1'b1, `SCG_OFF_CTRL, 32'h3);
    rd_wait(`SCG_OFF_CTRL, 32'h3);
    // Crystal dies while it drives the system clock
    apb(1'b1, `SCG_OFF_FAIL, 32'h1);
    @(posedge clk);
    kill <= 1'b1;
    watch(8);
    @(posedge clk);
    kill <= 1'b0;
    chk(nn > 0, 1);
    rd(`SCG_OFF_CTRL, 32'h0);
    rd(`SCG_OFF_OSCEN, 32'h1);
    chk(osc_en, 6'h01);
    rd(`SCG_OFF_FAIL, 32'h3);
    apb(1'b1, `SCG_OFF_RTC, 32'h6);
    chk(ulp_en, 1);
    @(posedge clk);
    deep <= 1'b1;
    watch(256);
    @(posedge clk);
    deep <= 1'b0;
    chk(nrtc, 64);
    chk(nper, 0);
    chk(nu, 2);
    chk(nr, 4);
    apb(1'b1, `SCG_OFF_RTC, 32'h0);
    chk(ulp_en, 0);
    apb(1'b1, `SCG_OFF_PLL, 32'h9f);
    chk({psrc, fac}, 7'h5f);
    apb(1'b1, `SCG_OFF_PLL, 32'h0);
    chk(fac, 5'h1f);
    apb(1'b1, `SCG_OFF_FREQUENCY_LOCK_CALIBRATOR, 32'h3);
    rd(`SCG_OFF_FREQUENCY_LOCK_CALIBRATOR, 32'h3);
    give_verdict();
  end
endmodule // system_clock_generation_unit_bench
